// [inc/pcs_pkg.sv]
// constants, types and register map of the program counter, shadow and multiplier block
package pcs_pkg;

  localparam int PC_W = 21;
  localparam int PC_MID_LSB = 8;
  localparam int PC_TOP_LSB = 16;
  localparam int PC_TOP_W = 5;

  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam logic [15:0] PROD_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // apb byte addresses
  localparam logic [11:0] OFS_PC_LOW = 12'h000;
  localparam logic [11:0] OFS_PC_HIGH_LATCH = 12'h004;
  localparam logic [11:0] OFS_PC_UPPER_LATCH = 12'h008;
  localparam logic [11:0] OFS_PROD_LOW = 12'h00C;
  localparam logic [11:0] OFS_PROD_HIGH = 12'h010;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SEQ,
    OP_LOAD,
    OP_CALL_FAST,
    OP_IRQ,
    OP_RET_FAST,
    OP_RETURN_FROM_INTERRUPT_INSTR_FAST,
    OP_WAKE,
    OP_MUL
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t op;
    logic [20:0] target;
    logic [7:0] operand;
    logic high_prio;
    logic gie_high;
    logic gie_low;
  } pcs_core_req_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } pcs_core_regs_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pcs_apb_req_t;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] high_latch;
    logic [7:0] upper_latch;
    pcs_core_regs_t shadow;
    pcs_core_regs_t restore;
    logic restore_vld;
    logic [15:0] product;
    logic [31:0] prdata;
  } pcs_state_t;

endpackage

// [logic/pcs_core_flow.sv]
// program counter with latches, one-deep register shadow and 8x8 multiplier
// Notes on behaviour
// - one saved copy each of status, working and bank-select registers
// - shadow copies have no bus address; only core sequencing touches them
// - interrupt entry saves status, working and bank into shadow; a wake-up vector load saves nothing
// - fast return-from-interrupt reloads the three registers from the shadow
// - a nested high-priority entry overwrites shadow saved by low-priority entry
// - fast call saves the three registers into the shadow like interrupts
// - fast subroutine return restores the three registers from the shadow
// - program counter is 21 bits; low byte is a normal register
// - bits 15..8 are reachable only through the high latch
// - bits 20..16 are reachable only through the upper latch
// - writing the low byte also loads both latches into the counter
// - reading the low byte copies both upper counter bytes into latches
// - counter bit 0 is always zero
// - sequential fetch advances the counter by two
// - call, relative call, goto and branch load the counter without latches
// - interrupt wake-up with a global enable set loads the matching vector
// - unsigned 8x8 multiply completes within one cycle
// - product high byte in upper register, low byte in lower
// - multiply leaves every status flag unchanged
// - multiply takes working register and the named file register
module pcs_core_flow
  import pcs_pkg::*;
(
  input wire logic mclk, // core clock, 100 MHz
  input wire logic rst_b, // async reset, active low
  input wire pcs_apb_req_t apb_req, // apb request signals
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped address
  input wire pcs_core_req_t core_req, // one sequencing operation per cycle
  input wire pcs_core_regs_t core_regs, // live status, working, bank values
  output logic [20:0] pc, // program counter
  output logic [15:0] product, // product register pair
  output logic restore_vld, // one-cycle pulse: load restore values
  output pcs_core_regs_t restore_regs // values to reload into the core
);

  pcs_state_t s_q;
  pcs_state_t s_d;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;
  logic pcl_wr;
  logic pcl_rd;
  logic high_wr;
  logic upper_wr;
  logic [20:0] vector_sel;

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_access = apb_req.psel && apb_req.penable;
  assign pcl_wr = apb_access && apb_req.pwrite && (apb_req.paddr == OFS_PC_LOW);
  assign pcl_rd = apb_access && !apb_req.pwrite && (apb_req.paddr == OFS_PC_LOW);
  assign high_wr = apb_access && apb_req.pwrite && (apb_req.paddr == OFS_PC_HIGH_LATCH);
  assign upper_wr = apb_access && apb_req.pwrite && (apb_req.paddr == OFS_PC_UPPER_LATCH);
  assign vector_sel = core_req.high_prio ? VEC_HIGH : VEC_LOW;

  // shadow offsets are deliberately absent from this decode
  always_comb
  begin
    unique case (apb_req.paddr)
      OFS_PC_LOW, OFS_PC_HIGH_LATCH, OFS_PC_UPPER_LATCH, OFS_PROD_LOW, OFS_PROD_HIGH:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;

  always_comb
  begin
    s_d = s_q;
    s_d.restore_vld = 1'b0;

    if (apb_setup)
    begin
      unique case (apb_req.paddr)
        OFS_PC_LOW: s_d.prdata = {24'h000000, s_q.pc[7:0]};
        OFS_PC_HIGH_LATCH: s_d.prdata = {24'h000000, s_q.high_latch};
        OFS_PC_UPPER_LATCH: s_d.prdata = {24'h000000, s_q.upper_latch};
        OFS_PROD_LOW: s_d.prdata = {24'h000000, s_q.product[7:0]};
        OFS_PROD_HIGH: s_d.prdata = {24'h000000, s_q.product[15:8]};
        default: s_d.prdata = RDATA_RESET;
      endcase
    end

    unique case (core_req.op)
      OP_NONE:
      begin
      end
      OP_SEQ:
        s_d.pc = s_q.pc + PC_STEP;
      OP_LOAD, OP_RET_FAST:
      begin
        s_d.pc = core_req.target;
        if (core_req.op == OP_RET_FAST)
        begin
          s_d.restore = s_q.shadow;
          s_d.restore_vld = 1'b1;
        end
      end
      OP_CALL_FAST:
      begin
        s_d.pc = core_req.target;
        s_d.shadow = core_regs;
      end
      OP_IRQ:
      begin
        // nested high-priority entry simply overwrites: one entry only
        s_d.shadow = core_regs;
        s_d.pc = vector_sel;
      end
      OP_RETURN_FROM_INTERRUPT_INSTR_FAST:
      begin
        s_d.pc = core_req.target;
        s_d.restore = s_q.shadow;
        s_d.restore_vld = 1'b1;
      end
      OP_WAKE:
      begin
        if (core_req.gie_high || core_req.gie_low)
          s_d.pc = vector_sel;
        else
          s_d.pc = s_q.pc + PC_STEP;
      end
      OP_MUL:
      begin
        // no status write path exists, so flags stay untouched
        s_d.product = 16'(core_regs.working) * 16'(core_req.operand);
        s_d.pc = s_q.pc + PC_STEP;
      end
      default:
      begin
      end
    endcase

    // a bus write of the low byte wins over a core load in the same cycle
    if (pcl_wr)
      s_d.pc = {s_q.upper_latch[PC_TOP_W-1:0], s_q.high_latch, apb_req.pwdata[7:0]};
    if (high_wr)
      s_d.high_latch = apb_req.pwdata[7:0];
    if (upper_wr)
      s_d.upper_latch = apb_req.pwdata[7:0];
    if (pcl_rd)
    begin
      s_d.high_latch = s_q.pc[15:PC_MID_LSB];
      s_d.upper_latch = {3'b000, s_q.pc[PC_W-1:PC_TOP_LSB]};
    end
    s_d.pc[0] = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.pc <= PC_RESET;
      s_q.high_latch <= LATCH_RESET;
      s_q.upper_latch <= LATCH_RESET;
      s_q.shadow <= {SHADOW_RESET, SHADOW_RESET, SHADOW_RESET};
      s_q.restore <= {SHADOW_RESET, SHADOW_RESET, SHADOW_RESET};
      s_q.restore_vld <= 1'b0;
      s_q.product <= PROD_RESET;
      s_q.prdata <= RDATA_RESET;
    end
    else
      s_q <= s_d;
  end

  assign pc = s_q.pc;
  assign product = s_q.product;
  assign prdata = s_q.prdata;
  assign restore_vld = s_q.restore_vld;
  assign restore_regs = s_q.restore;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_pc_bit0_zero: assert property (pc[0] == 1'b0)
    else $error("program counter bit 0 is not zero");

  a_seq_step_two: assert property (core_req.op == OP_SEQ && !pcl_wr |=> pc == $past(pc) + PC_STEP)
    else $error("sequential fetch did not advance by two");

  a_pcl_write_latch: assert property (pcl_wr |=> pc == {$past(upper_latch_top()), $past(s_q.high_latch),
    $past(apb_req.pwdata[7:1]), 1'b0})
    else $error("low byte write did not merge latches");

  a_pcl_read_copy: assert property (pcl_rd |=> s_q.high_latch == $past(pc[15:8])
    && s_q.upper_latch == {3'b000, $past(pc[20:16])})
    else $error("low byte read did not refresh latches");

  a_load_direct_pc: assert property ((core_req.op == OP_LOAD || core_req.op == OP_CALL_FAST) && !pcl_wr
    |=> pc == {$past(core_req.target[20:1]), 1'b0})
    else $error("direct load used latch contents");

  a_irq_shadow_save: assert property (core_req.op == OP_IRQ |=> s_q.shadow == $past(core_regs))
    else $error("interrupt entry did not save registers");

  a_irq_vector_pc: assert property (core_req.op == OP_IRQ && !pcl_wr
    |=> pc == ($past(core_req.high_prio) ? VEC_HIGH : VEC_LOW))
    else $error("interrupt entry loaded the wrong vector");

  a_fast_return_restore: assert property (core_req.op == OP_RETURN_FROM_INTERRUPT_INSTR_FAST || core_req.op == OP_RET_FAST
    |=> restore_vld && restore_regs == $past(s_q.shadow)
    ##1 (restore_vld == $past(core_req.op inside {OP_RETURN_FROM_INTERRUPT_INSTR_FAST, OP_RET_FAST})))
    else $error("fast return did not restore shadow for one cycle");

  a_shadow_hold: assert property (!(core_req.op inside {OP_IRQ, OP_CALL_FAST})
    |=> $stable(s_q.shadow))
    else $error("shadow changed without entry or fast call");

  a_mul_product: assert property (core_req.op == OP_MUL
    |=> product == 16'($past(core_regs.working)) * 16'($past(core_req.operand)))
    else $error("product wrong one cycle after multiply");

  a_mul_no_flags: assert property (core_req.op == OP_MUL |=> !restore_vld)
    else $error("multiply disturbed core register state");

  function automatic logic [4:0] upper_latch_top();
    return s_q.upper_latch[PC_TOP_W-1:0];
  endfunction

endmodule

// [testbench/pcs_core_flow_tb_top.sv]
// self-checking bench of the program counter, shadow and multiplier block
module pcs_core_flow_tb_top
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  pcs_apb_req_t apb = '0;
  pcs_core_req_t rq = '0;
  pcs_core_regs_t rg = '0;
  logic pready, pslverr, rvld;
  logic [31:0] prdata;
  logic [20:0] pc;
  logic [15:0] prod;
  pcs_core_regs_t rr;
  logic [20:0] m_pc;
  logic [7:0] m_hl, m_ul;
  pcs_core_regs_t m_sh, m_rr;
  logic [15:0] m_prod;
  logic [7:0] m_a, m_b;
  logic m_rv;
  logic [31:0] m_rd;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h6C77BA24;
  logic [11:0] ads [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'hFFC};
  pcs_op_t ops [9] = '{OP_IRQ, OP_SEQ, OP_IRQ, OP_RETURN_FROM_INTERRUPT_INSTR_FAST, OP_CALL_FAST, OP_MUL,
    OP_RET_FAST, OP_WAKE, OP_LOAD};

  always #5 mclk = ~mclk;

  pcs_core_flow i_pcs_core_flow (.mclk(mclk), .rst_b(rst_b), .apb_req(apb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .core_req(rq), .core_regs(rg), .pc(pc),
    .product(prod), .restore_vld(rvld), .restore_regs(rr));

  // ----------------------------------------
  // reference model and drivers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function pcs_core_req_t rreq(input logic [3:0] k);
    logic [31:0] a, b;
    a = rnd();
    b = rnd();
    rreq = '{op: pcs_op_t'(k), target: a[20:0], operand: b[7:0], high_prio: b[8],
      gie_high: b[9], gie_low: b[10]};
  endfunction

  // software sign correction on the high byte of an unsigned product
  function logic [15:0] sfix(input logic [15:0] p, input logic [7:0] a, input logic [7:0] b);
    sfix = p - (a[7] ? {b, 8'h00} : 16'h0000) - (b[7] ? {a, 8'h00} : 16'h0000);
  endfunction

  task chk(input logic ok, input string m);
    checks_done++;
    if (!ok)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // called at the edge that takes the request, before new values land
  task apply();
    logic [20:0] old;
    old = m_pc;
    m_rv = 1'b0;
    if (apb.psel && !apb.penable)
      case (apb.paddr)
        OFS_PC_LOW: m_rd = {24'h000000, m_pc[7:0]};
        OFS_PC_HIGH_LATCH: m_rd = {24'h000000, m_hl};
        OFS_PC_UPPER_LATCH: m_rd = {24'h000000, m_ul};
        OFS_PROD_LOW: m_rd = {24'h000000, m_prod[7:0]};
        OFS_PROD_HIGH: m_rd = {24'h000000, m_prod[15:8]};
        default: m_rd = 32'h00000000;
      endcase
    case (rq.op)
      OP_SEQ, OP_MUL: m_pc = old + PC_STEP;
      OP_LOAD, OP_CALL_FAST: m_pc = rq.target & ~21'h000001;
      OP_IRQ: m_pc = rq.high_prio ? VEC_HIGH : VEC_LOW;
      OP_WAKE: m_pc = (rq.gie_high | rq.gie_low) ? (rq.high_prio ? VEC_HIGH : VEC_LOW) : old + PC_STEP;
      OP_RET_FAST, OP_RETURN_FROM_INTERRUPT_INSTR_FAST: m_rv = 1'b1;
      default: ;
    endcase
    if (m_rv) m_pc = rq.target & ~21'h000001;
    if (m_rv) m_rr = m_sh;
    if (rq.op == OP_MUL)
    begin
      m_prod = {8'h00, rg.working} * {8'h00, rq.operand};
      m_a = rg.working;
      m_b = rq.operand;
    end
    if (rq.op == OP_IRQ || rq.op == OP_CALL_FAST) m_sh = rg;
    if (apb.psel && apb.penable && apb.pwrite)
      case (apb.paddr)
        OFS_PC_LOW: m_pc = {m_ul[4:0], m_hl, apb.pwdata[7:1], 1'b0};
        OFS_PC_HIGH_LATCH: m_hl = apb.pwdata[7:0];
        OFS_PC_UPPER_LATCH: m_ul = apb.pwdata[7:0];
        default: ;
      endcase
    if (apb.psel && apb.penable && !apb.pwrite && apb.paddr == OFS_PC_LOW)
    begin
      m_hl = old[15:8];
      m_ul = {3'b000, old[20:16]};
    end
  endtask

  task cmp();
    chk(pc === m_pc, "program counter");
    chk(prod === m_prod, "product");
    chk(sfix(prod, m_a, m_b) === {{8{m_a[7]}}, m_a} * {{8{m_b[7]}}, m_b}, "signed fix");
    chk(rvld === m_rv, "restore pulse");
    if (m_rv) chk(rr === m_rr, "restore values");
    chk(prdata === m_rd, "read data");
    if (apb.psel && apb.penable) chk(pready === 1'b1 && pslverr === !(apb.paddr inside
      {OFS_PC_LOW, OFS_PC_HIGH_LATCH, OFS_PC_UPPER_LATCH, OFS_PROD_LOW, OFS_PROD_HIGH}),
      "apb answer");
  endtask

  task cyc(input pcs_core_req_t r, input pcs_apb_req_t a);
    logic [31:0] w;
    @(posedge mclk);
    apply();
    w = rnd();
    rq <= r;
    apb <= a;
    rg <= w[23:0];
    @(negedge mclk);
    cmp();
  endtask

  task apb_xfer(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
    pcs_apb_req_t a;
    a = '{paddr: ad, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    cyc('0, a);
    a.penable = 1'b1;
    cyc('0, a);
    for (int n = 0; n < 8 && pready !== 1'b1; n++) cyc('0, a);
  endtask

  task do_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    rq <= '0;
    apb <= '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    m_pc = PC_RESET;
    m_hl = LATCH_RESET;
    m_ul = LATCH_RESET;
    m_sh = {3{SHADOW_RESET}};
    m_prod = PROD_RESET;
    m_a = 8'h00;
    m_b = 8'h00;
    m_rv = 1'b0;
    m_rd = RDATA_RESET;
    @(negedge mclk);
    cmp();
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] k;
    do_reset();
    $display("reset test done");
    for (int i = 0; i < 9; i++) cyc(rreq(ops[i]), '0);
    $display("nested shadow test done");
    repeat (400) cyc(rreq(4'(rnd() % 9)), '0);
    $display("random core test done");
    for (int i = 0; i < 60; i++)
    begin
      k = rnd();
      apb_xfer(ads[k % 7], k[3], rnd());
      cyc(rreq(4'(rnd() % 9)), '0);
    end
    $display("register test done");
    do_reset();
    $display("second reset test done");
    summarize();
  end

  initial
  begin
    #50us;
    err_count++;
    summarize();
  end
endmodule
